// file: shared/icp_pkg.sv
// ---------------------------------------------------------------------
// Shared constants for the control, command and divider registers
// ---------------------------------------------------------------------
package icp_pkg;

  // -------------------------------------------------------------------
  // System bus geometry
  // -------------------------------------------------------------------
  localparam int ADDR_W = 4;   // Register address width
  localparam int DATA_W = 10;  // Bus data width, only the low byte lane is used
  localparam int REG_W  = 8;   // Width of every register here

  // Register addresses on the 4-bit bus
  localparam logic [ADDR_W-1:0] ADDR_CONTROL_ONE = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_DIV_LOW     = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_DIV_HIGH    = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_COMMAND     = 4'h7;

  // Reset values
  localparam logic [REG_W-1:0] RST_CONTROL_ONE = 8'h00;
  localparam logic [REG_W-1:0] RST_COMMAND     = 8'h00;
  localparam logic [REG_W-1:0] RST_DIV_LOW     = 8'h00;
  localparam logic [REG_W-1:0] RST_DIV_HIGH    = 8'h00;

  // Writable bit masks; reserved bits are dropped on write
  localparam logic [REG_W-1:0] MASK_CONTROL_ONE = 8'hFE;
  localparam logic [REG_W-1:0] MASK_COMMAND     = 8'hFE;
  localparam logic [REG_W-1:0] MASK_DIV_LOW     = 8'hFF;
  localparam logic [REG_W-1:0] MASK_DIV_HIGH    = 8'hF3;

  // -------------------------------------------------------------------
  // Field positions
  // -------------------------------------------------------------------
  // Control-one
  localparam int CO_CORE_ENABLE   = 7;
  localparam int CO_GENERAL_CALL  = 6;
  localparam int CO_SLEEP_WAKE    = 5;
  localparam int CO_QUEUE_MODE    = 4;
  localparam int CO_DELAY_SEL_HI  = 3;
  localparam int CO_DELAY_SEL_LO  = 2;
  localparam int CO_STRETCH_OFF_Q = 1;
  // Command
  localparam int CM_START         = 7;
  localparam int CM_STOP          = 6;
  localparam int CM_READ          = 5;
  localparam int CM_WRITE         = 4;
  localparam int CM_NACK          = 3;
  localparam int CM_STRETCH_OFF_R = 2;
  localparam int CM_READ_BYPASS   = 1;
  // Divider high byte
  localparam int DH_BASE_HI       = 7;
  localparam int DH_BASE_LO       = 4;
  localparam int DH_DIV_HI        = 1;
  localparam int DH_DIV_LO        = 0;

  // -------------------------------------------------------------------
  // SCL divider and SDA delay
  // -------------------------------------------------------------------
  localparam int DIV_W   = 10;          // Divider value width
  localparam int DELAY_W = 6;           // Widest delay is 4*15+3
  localparam longint CLK_HZ         = 125_000_000;
  localparam longint SCL_DEFAULT_HZ = 400_000;
  localparam longint SCL_PHASES     = 4; // Ticks per SCL period
  // Round the count up so the default never exceeds 400 kHz
  localparam logic [DIV_W-1:0] DIV_DEFAULT = DIV_W'(
    (CLK_HZ + SCL_PHASES * SCL_DEFAULT_HZ - 1) /
    (SCL_PHASES * SCL_DEFAULT_HZ) - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = 10'h000;

  localparam logic [DELAY_W-1:0] DELAY_ADD  = 6'h03; // Fixed part
  localparam logic [DELAY_W-1:0] DELAY_MIN  = 6'h01; // Base of zero
  localparam logic [DELAY_W-1:0] DELAY_NONE = 6'h00; // Code 11
  localparam logic [3:0]         BASE_ZERO  = 4'h0;

  // Delay select codes
  typedef enum logic [1:0] {
    DSEL_X4   = 2'h0,
    DSEL_X2   = 2'h1,
    DSEL_X1   = 2'h2,
    DSEL_NONE = 2'h3
  } icp_delay_sel_t;

endpackage

// file: shared/icp_div_if.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------------
// Link between the register block and the SCL divider
// ---------------------------------------------------------------------
interface icp_div_if;
  logic [icp_pkg::DIV_W-1:0] divider;  // Effective divider, never zero
  logic                      hold;     // Keep the divider in its idle state
  logic                      tick;     // One-cycle quarter-period enable

  // Register side
  modport ctrl (output divider, output hold, input tick);
  // Divider side
  modport gen  (input divider, input hold, output tick);
endinterface

// file: hw/icp_scl_divider.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------------
// SCL quarter-period enable generator
// ---------------------------------------------------------------------
module icp_scl_divider
  import icp_pkg::*;
(
  input  wire logic clk_i,   // System bus clock
  input  wire logic rst_i,   // Async reset, active high
  icp_div_if.gen    div      // Divider value, hold and tick
);

  logic [DIV_W-1:0] count;       // Cycles left in this quarter
  logic [DIV_W-1:0] next_count;  // Next counter value
  logic             next_tick;   // Next tick value
  logic             wrap;        // Quarter period ends this cycle

  // -------------------------------------------------------------------
  // Count N+1 cycles per tick, four ticks per SCL period
  // -------------------------------------------------------------------
  assign wrap       = (count == DIV_ZERO);
  assign next_tick  = !div.hold && wrap;
  assign next_count = div.hold ? div.divider :
                      wrap     ? div.divider :
                      count - DIV_W'(1);

  // Counter and tick register; hold restarts a full quarter
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count    <= DIV_ZERO;
      div.tick <= 1'b0;
    end else begin
      count    <= next_count;
      div.tick <= next_tick;
    end
  end

endmodule

// file: hw/icp_ctrl_regs.sv
`timescale 1ns/1ns
// How it works
// - Control-one write pulses core reset
// - Enable bit low holds core idle
// - General call answered only when enabled
// - Wake on address match when enabled
// - Queue mode bit picks register or FIFO
// - Delay select code sets SDA delay
// - FIFO mode stretch-off bit stops stretching
// - Command bypass bit forced zero in FIFO
// - Start bit requests START or repeated START
// - Stop bit requests STOP condition
// - Read and write bits pick direction
// - Command bit 3 picks ACK or NACK
// - Register mode stretch-off bit stops stretching
// - Bypass bit disables receive double buffering
// - Divider split over low and high bytes
// - Divider byte write pulses core reset
// - SCL is clock over four times N+1
// - Zero divider selects built-in 400 kHz default
// - Registers decoded at 1, 2, 3, 7
// - Acknowledge follows strobe, drops after it
module icp_ctrl_regs
  import icp_pkg::*;
(
  input  wire logic               SYS_CLK_I,            // System clock
  input  wire logic               RST_I,                // Async reset
  // -------------------------------------------------------------------
  // System bus slave
  // -------------------------------------------------------------------
  input  wire logic               BUS_STROBE_I,         // Transfer strobe
  input  wire logic               BUS_WRITE_I,          // 1 write, 0 read
  input  wire logic [ADDR_W-1:0]  BUS_ADDR_I,           // Register address
  input  wire logic [DATA_W-1:0]  BUS_WDATA_I,          // Write data
  output logic      [DATA_W-1:0]  BUS_RDATA_O,          // Read data
  output logic                    BUS_ACKNOWLEDGE_O,    // Transfer ack
  // -------------------------------------------------------------------
  // Core status inputs
  // -------------------------------------------------------------------
  input  wire logic               SLEEP_I,              // Device asleep
  input  wire logic               ADDR_MATCH_I,         // Own addr matched
  input  wire logic               GC_ADDR_SEEN_I,       // All-zero address
  // -------------------------------------------------------------------
  // Core controls
  // -------------------------------------------------------------------
  output logic                    CORE_RESET_O,         // Core reset pulse
  output logic                    CORE_ENABLE_O,        // Core enabled
  output logic                    GC_RESPOND_O,         // Answer gen. call
  output logic                    WAKE_O,               // Wake-up request
  output logic                    QUEUE_MODE_O,         // 1 FIFO, 0 reg
  output logic                    STRETCH_OFF_O,        // No stretching
  output logic                    START_REQUEST_O,      // START wanted
  output logic                    STOP_REQUEST_O,       // STOP wanted
  output logic                    READ_REQUEST_O,       // Read from slave
  output logic                    WRITE_REQUEST_O,      // Write to slave
  output logic                    NACK_SELECT_O,        // 1 NACK, 0 ACK
  output logic                    READ_BUFFER_BYPASS_O, // No dbl buffer
  output logic                    SCL_TICK_O,           // Quarter SCL tick
  output logic      [DELAY_W-1:0] SDA_DELAY_O           // SDA delay cycles
);

  // -------------------------------------------------------------------
  // Declarations
  // -------------------------------------------------------------------
  typedef enum logic {BUS_IDLE, BUS_ACK} icp_bus_state_t;

  icp_bus_state_t   bus_state;        // Bus handshake state
  icp_bus_state_t   next_bus_state;   // Next handshake state
  logic [REG_W-1:0] core_control_one; // Control-one register
  logic [REG_W-1:0] master_command;   // Command register
  logic [REG_W-1:0] scl_divider_low;  // Divider bits 7..0
  logic [REG_W-1:0] scl_divider_high; // Base delay and bits 9..8
  logic [REG_W-1:0] wdata;            // Byte lane of write data
  logic [REG_W-1:0] rdata;            // Selected read byte

  icp_div_if div_link ();             // Link to the SCL divider

  // -------------------------------------------------------------------
  // Bus decode
  // -------------------------------------------------------------------
  logic take;            // Request taken this cycle
  logic wr_take;         // Write taken this cycle
  logic sel_control;     // Control-one addressed
  logic sel_command;     // Command addressed
  logic sel_div_low;     // Divider low addressed
  logic sel_div_high;    // Divider high addressed
  logic wr_control;      // Write to control-one
  logic wr_command;      // Write to command
  logic wr_div_low;      // Write to divider low
  logic wr_div_high;     // Write to divider high
  logic reset_write;     // Any write that resets the core

  // A request is taken once, on the first strobe cycle with ack low
  assign take        = BUS_STROBE_I && (bus_state == BUS_IDLE);
  assign wr_take     = take && BUS_WRITE_I;
  assign sel_control = (BUS_ADDR_I == ADDR_CONTROL_ONE);
  assign sel_div_low = (BUS_ADDR_I == ADDR_DIV_LOW);
  assign sel_div_high= (BUS_ADDR_I == ADDR_DIV_HIGH);
  assign sel_command = (BUS_ADDR_I == ADDR_COMMAND);
  assign wr_control  = wr_take && sel_control;
  assign wr_command  = wr_take && sel_command;
  assign wr_div_low  = wr_take && sel_div_low;
  assign wr_div_high = wr_take && sel_div_high;
  // Control and divider writes restart the core
  assign reset_write = wr_control || wr_div_low || wr_div_high;
  // Only the low byte lane carries register data
  assign wdata       = BUS_WDATA_I[REG_W-1:0];

  // -------------------------------------------------------------------
  // Handshake state
  // -------------------------------------------------------------------
  // Ack rises one cycle after the strobe, falls one after it drops
  always_comb begin
    next_bus_state = bus_state;
    case (bus_state)
      BUS_IDLE: begin
        if (BUS_STROBE_I) begin
          next_bus_state = BUS_ACK;
        end
      end
      BUS_ACK: begin
        if (!BUS_STROBE_I) begin
          next_bus_state = BUS_IDLE;
        end
      end
      default: begin
        next_bus_state = BUS_IDLE;
      end
    endcase
  end

  // State and acknowledge flop
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      bus_state         <= BUS_IDLE;
      BUS_ACKNOWLEDGE_O <= 1'b0;
    end else begin
      bus_state         <= next_bus_state;
      BUS_ACKNOWLEDGE_O <= (next_bus_state == BUS_ACK);
    end
  end

  // -------------------------------------------------------------------
  // Register storage
  // -------------------------------------------------------------------
  // Control-one; reserved bit 0 never stores
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      core_control_one <= RST_CONTROL_ONE;
    end else if (wr_control) begin
      core_control_one <= wdata & MASK_CONTROL_ONE;
    end
  end

  // Command; in FIFO mode the bypass bit stays at zero
  logic [REG_W-1:0] cmd_mask;  // Writable command bits now
  logic             queue_on;  // FIFO mode selected
  assign queue_on = core_control_one[CO_QUEUE_MODE];
  assign cmd_mask = queue_on ?
    (MASK_COMMAND & ~(REG_W'(1) << CM_READ_BYPASS)) :
    MASK_COMMAND;

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      master_command <= RST_COMMAND;
    end else if (wr_command) begin
      master_command <= wdata & cmd_mask;
    end else if (queue_on) begin
      // Entering FIFO mode drops a stale bypass request
      master_command[CM_READ_BYPASS] <= 1'b0;
    end
  end

  // Divider bytes; two separate writes build the 10-bit value
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      scl_divider_low  <= RST_DIV_LOW;
      scl_divider_high <= RST_DIV_HIGH;
    end else begin
      if (wr_div_low) begin
        scl_divider_low  <= wdata & MASK_DIV_LOW;
      end
      if (wr_div_high) begin
        scl_divider_high <= wdata & MASK_DIV_HIGH;
      end
    end
  end

  // -------------------------------------------------------------------
  // Read path
  // -------------------------------------------------------------------
  // Unmapped addresses and the upper lane read as zero
  assign rdata = sel_control  ? core_control_one :
                 sel_command  ? master_command :
                 sel_div_low  ? scl_divider_low :
                 sel_div_high ? scl_divider_high :
                 RST_COMMAND;

  // Data captured when the request is taken, held through the ack
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      BUS_RDATA_O <= '0;
    end else if (take && !BUS_WRITE_I) begin
      BUS_RDATA_O <= {{(DATA_W-REG_W){1'b0}}, rdata};
    end
  end

  // -------------------------------------------------------------------
  // SCL divider
  // -------------------------------------------------------------------
  logic [DIV_W-1:0] div_raw;  // Programmed 10-bit value
  logic             enabled;  // Core enable bit
  assign enabled = core_control_one[CO_CORE_ENABLE];
  assign div_raw = {scl_divider_high[DH_DIV_HI:DH_DIV_LO],
                    scl_divider_low};
  // Zero means the built-in 400 kHz default
  assign div_link.divider = (div_raw == DIV_ZERO) ?
                            DIV_DEFAULT : div_raw;
  // Held while disabled or while the core reset is applied
  assign div_link.hold    = !enabled || reset_write
                            || CORE_RESET_O;

  icp_scl_divider u_divider (
    .clk_i (SYS_CLK_I),
    .rst_i (RST_I),
    .div   (div_link.gen)
  );

  // -------------------------------------------------------------------
  // SDA output delay
  // -------------------------------------------------------------------
  logic [3:0]         base;       // Delay base from divider high
  logic [DELAY_W-1:0] base_w;     // Base at delay width
  logic [DELAY_W-1:0] next_delay; // Decoded delay
  icp_delay_sel_t     dsel;       // Delay select code
  assign base   = scl_divider_high[DH_BASE_HI:DH_BASE_LO];
  assign base_w = DELAY_W'(base);
  assign dsel   = icp_delay_sel_t'(
    core_control_one[CO_DELAY_SEL_HI:CO_DELAY_SEL_LO]);
  // Zero base shortens every scaled code to a single cycle
  assign next_delay =
    (dsel == DSEL_NONE) ? DELAY_NONE :
    (base == BASE_ZERO) ? DELAY_MIN :
    (dsel == DSEL_X4)   ? (base_w << 2) + DELAY_ADD :
    (dsel == DSEL_X2)   ? (base_w << 1) + DELAY_ADD :
    base_w + DELAY_ADD;

  // -------------------------------------------------------------------
  // Registered core controls
  // -------------------------------------------------------------------
  logic stretch_off;  // Stretch-off bit of the active mode
  // The mode bit decides which stretch-off bit counts
  assign stretch_off = queue_on ?
    core_control_one[CO_STRETCH_OFF_Q] :
    master_command[CM_STRETCH_OFF_R];

  // Every output is a flop; disabled core sees no START, STOP, read or write requests
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      CORE_RESET_O         <= 1'b0;
      CORE_ENABLE_O        <= 1'b0;
      GC_RESPOND_O         <= 1'b0;
      WAKE_O               <= 1'b0;
      QUEUE_MODE_O         <= 1'b0;
      STRETCH_OFF_O        <= 1'b0;
      START_REQUEST_O      <= 1'b0;
      STOP_REQUEST_O       <= 1'b0;
      READ_REQUEST_O       <= 1'b0;
      WRITE_REQUEST_O      <= 1'b0;
      NACK_SELECT_O        <= 1'b0;
      READ_BUFFER_BYPASS_O <= 1'b0;
      SCL_TICK_O           <= 1'b0;
      SDA_DELAY_O          <= DELAY_NONE;
    end else begin
      CORE_RESET_O         <= reset_write;
      CORE_ENABLE_O        <= enabled;
      GC_RESPOND_O         <= enabled && GC_ADDR_SEEN_I
        && core_control_one[CO_GENERAL_CALL];
      WAKE_O               <= SLEEP_I && ADDR_MATCH_I
        && core_control_one[CO_SLEEP_WAKE];
      QUEUE_MODE_O         <= queue_on;
      STRETCH_OFF_O        <= stretch_off;
      START_REQUEST_O      <= enabled
        && master_command[CM_START];
      STOP_REQUEST_O       <= enabled
        && master_command[CM_STOP];
      READ_REQUEST_O       <= enabled
        && master_command[CM_READ];
      WRITE_REQUEST_O      <= enabled
        && master_command[CM_WRITE];
      NACK_SELECT_O        <= master_command[CM_NACK];
      READ_BUFFER_BYPASS_O <= !queue_on
        && master_command[CM_READ_BYPASS];
      SCL_TICK_O           <= div_link.tick;
      SDA_DELAY_O          <= next_delay;
    end
  end

endmodule

// file: verif/icp_ctrl_regs_assertions.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------------
// Port checks for the control register block
// ---------------------------------------------------------------------
module icp_ctrl_regs_assertions
  import icp_pkg::*;
(
  input wire logic              SYS_CLK_I,
  input wire logic              RST_I,
  input wire logic              BUS_STROBE_I,
  input wire logic              BUS_WRITE_I,
  input wire logic [ADDR_W-1:0] BUS_ADDR_I,
  input wire logic [DATA_W-1:0] BUS_RDATA_O,
  input wire logic              BUS_ACKNOWLEDGE_O,
  input wire logic              SLEEP_I,
  input wire logic              ADDR_MATCH_I,
  input wire logic              GC_ADDR_SEEN_I,
  input wire logic              CORE_RESET_O,
  input wire logic              CORE_ENABLE_O,
  input wire logic              GC_RESPOND_O,
  input wire logic              WAKE_O,
  input wire logic              QUEUE_MODE_O,
  input wire logic              START_REQUEST_O,
  input wire logic              STOP_REQUEST_O,
  input wire logic              READ_BUFFER_BYPASS_O,
  input wire logic              SCL_TICK_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  // Write taken at a register that resets the core
  wire logic reg_write = BUS_STROBE_I && !BUS_ACKNOWLEDGE_O && BUS_WRITE_I
    && (BUS_ADDR_I inside {ADDR_CONTROL_ONE, ADDR_DIV_LOW, ADDR_DIV_HIGH});

  chk_ack_answers: assert property (
    BUS_STROBE_I && !BUS_ACKNOWLEDGE_O |=> BUS_ACKNOWLEDGE_O)
    else $error("ack missing after strobe");
  chk_ack_releases: assert property (
    BUS_ACKNOWLEDGE_O && !BUS_STROBE_I |=> !BUS_ACKNOWLEDGE_O)
    else $error("ack held after strobe drop");
  chk_reset_on_write: assert property (
    reg_write |=> CORE_RESET_O ##1 !CORE_RESET_O)
    else $error("core reset pulse wrong");
  chk_reset_cause: assert property (!reg_write |=> !CORE_RESET_O)
    else $error("core reset without write");
  chk_disabled_idle: assert property (!CORE_ENABLE_O |->
    !START_REQUEST_O && !STOP_REQUEST_O) else $error("request while off");
  chk_gc_cause: assert property (!GC_ADDR_SEEN_I |=> !GC_RESPOND_O)
    else $error("general call answer without address");
  chk_wake_cause: assert property (!(SLEEP_I && ADDR_MATCH_I) |=>
    !WAKE_O) else $error("wake without sleep match");
  chk_bypass_fifo: assert property (QUEUE_MODE_O |->
    !READ_BUFFER_BYPASS_O) else $error("bypass set in queue mode");
  chk_tick_pulse: assert property (
    $rose(SCL_TICK_O) |=> !SCL_TICK_O)
    else $error("tick wider than one cycle");
  chk_rdata_upper: assert property (BUS_RDATA_O[9:8] == 2'h0)
    else $error("read data upper bits set");
  // Main scenarios reached
  cov_reg_write: cover property (reg_write ##1 CORE_RESET_O);
  cov_gc: cover property (GC_RESPOND_O);
  cov_wake: cover property (WAKE_O);
endmodule

bind icp_ctrl_regs icp_ctrl_regs_assertions u_chk (.SYS_CLK_I, .RST_I,
  .BUS_STROBE_I, .BUS_WRITE_I, .BUS_ADDR_I, .BUS_RDATA_O, .BUS_ACKNOWLEDGE_O,
  .SLEEP_I, .ADDR_MATCH_I, .GC_ADDR_SEEN_I, .CORE_RESET_O, .CORE_ENABLE_O,
  .GC_RESPOND_O, .WAKE_O, .QUEUE_MODE_O, .START_REQUEST_O, .STOP_REQUEST_O,
  .READ_BUFFER_BYPASS_O, .SCL_TICK_O);

// file: verif/icp_sb_master.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------------
// System bus master model
// ---------------------------------------------------------------------
module icp_sb_master
  import icp_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              ack_i,
  input  wire logic [DATA_W-1:0] rdata_i,
  output logic                   strobe_o,
  output logic                   write_o,
  output logic      [ADDR_W-1:0] addr_o,
  output logic      [DATA_W-1:0] wdata_o
);
  // Idle bus at time zero
  initial begin
    strobe_o = 1'b0;
    write_o  = 1'b0;
    addr_o   = 4'h0;
    wdata_o  = 10'h000;
  end
  // One access; request held until ack is sampled high or 16 cycles pass
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d,
                      output logic [DATA_W-1:0] q, output bit ok);
    int n;
    n = 0;
    @(negedge clk_i);
    strobe_o = 1'b1;
    write_o  = w;
    addr_o   = a;
    wdata_o  = d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 16);
    q = rdata_i;
    // A missing ack is reported to the caller, never swallowed
    ok = (ack_i === 1'b1);
    @(negedge clk_i);
    // Released lines toggle so a stale value is never trusted
    strobe_o = 1'b0;
    write_o  = ~write_o;
    addr_o   = ~addr_o;
    wdata_o  = ~wdata_o;
    @(posedge clk_i);
  endtask
endmodule

// file: verif/tb.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------------
// Testbench for the control register block
// ---------------------------------------------------------------------
module tb;
  import icp_pkg::*;
  logic clk = 1'b0, rst = 1'b1, sleep = 1'b0, match = 1'b0, gc = 1'b0;
  logic stb, wen, ack, crst, en, gcr, wk, qm, so, start_request, stop_request, rdq, wrq, nk, bp;
  logic tick;
  logic [ADDR_W-1:0] adr;
  logic [DATA_W-1:0] wd, rd_d;
  logic [DELAY_W-1:0] dly;
  int n_mismatch = 0, checks = 0, cyc = 0, n_rst = 0;

  always #4 clk = ~clk;
  icp_sb_master u_bus (.clk_i(clk), .ack_i(ack), .rdata_i(rd_d),
    .strobe_o(stb), .write_o(wen), .addr_o(adr), .wdata_o(wd));
  icp_ctrl_regs u_dut (.SYS_CLK_I(clk), .RST_I(rst), .BUS_STROBE_I(stb),
    .BUS_WRITE_I(wen), .BUS_ADDR_I(adr), .BUS_WDATA_I(wd), .BUS_RDATA_O(rd_d),
    .BUS_ACKNOWLEDGE_O(ack), .SLEEP_I(sleep), .ADDR_MATCH_I(match),
    .GC_ADDR_SEEN_I(gc), .CORE_RESET_O(crst), .CORE_ENABLE_O(en),
    .GC_RESPOND_O(gcr), .WAKE_O(wk), .QUEUE_MODE_O(qm), .STRETCH_OFF_O(so),
    .START_REQUEST_O(start_request), .STOP_REQUEST_O(stop_request), .READ_REQUEST_O(rdq),
    .WRITE_REQUEST_O(wrq), .NACK_SELECT_O(nk), .READ_BUFFER_BYPASS_O(bp),
    .SCL_TICK_O(tick), .SDA_DELAY_O(dly));

  // Hang guard and count of core reset pulses
  always @(posedge clk) begin
    cyc++;
    if (crst === 1'b1) n_rst++;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [9:0] q;
    bit ok;
    u_bus.xfer(1'b1, a, {2'h0, d}, q, ok);
    cmp(10'(ok), 10'h001);
  endtask
  task automatic rd(input logic [3:0] a, output logic [9:0] q);
    bit ok;
    u_bus.xfer(1'b0, a, 10'h000, q, ok);
    cmp(10'(ok), 10'h001);
  endtask
  // Cycles between two ticks, 0 if none within the bound
  task automatic period(output int n);
    int w;
    w = 0;
    n = 0;
    while (tick !== 1'b1 && w < 600) begin
      @(posedge clk);
      w++;
    end
    if (w < 600) begin
      do begin
        @(posedge clk);
        n++;
      end while (tick !== 1'b1 && n < 600);
    end
  endtask
  // Reset values, decode and unmapped space
  task automatic s_map();
    logic [9:0] q;
    logic [3:0] regs [4] = '{ADDR_CONTROL_ONE, ADDR_DIV_LOW, ADDR_DIV_HIGH,
                             ADDR_COMMAND};
    foreach (regs[i]) begin
      rd(regs[i], q);
      cmp(q, 10'h000);
    end
    cmp(10'(dly), 10'h001);
    wr(4'h5, 8'hFF);
    rd(4'h5, q);
    cmp(q, 10'h000);
  endtask
  // Control and command fields in both modes
  task automatic s_fields();
    logic [9:0] q;
    wr(ADDR_CONTROL_ONE, 8'hFF);
    rd(ADDR_CONTROL_ONE, q);
    cmp(q, 10'h0FE);
    cmp({7'h00, en, qm, so}, 10'h007);
    wr(ADDR_COMMAND, 8'hFF);
    rd(ADDR_COMMAND, q);
    cmp(q, 10'h0FC);
    cmp({4'h0, start_request, stop_request, rdq, wrq, nk, bp}, 10'h03E);
    wr(ADDR_CONTROL_ONE, 8'h80);
    wr(ADDR_COMMAND, 8'hFE);
    rd(ADDR_COMMAND, q);
    cmp(q, 10'h0FE);
    cmp({8'h00, so, bp}, 10'h003);
    wr(ADDR_COMMAND, 8'h00);
    cmp({4'h0, start_request, stop_request, rdq, wrq, so, bp}, 10'h000);
    wr(ADDR_COMMAND, 8'hF0);
    wr(ADDR_CONTROL_ONE, 8'h00);
    cmp({6'h00, start_request, stop_request, rdq, wrq}, 10'h000);
    cmp(10'(n_rst), 10'h003);
  endtask
  // Delay for every code and a spread of bases
  task automatic s_delay();
    logic [3:0] b [3] = '{4'h0, 4'h9, 4'hF};
    foreach (b[i]) begin
      wr(ADDR_DIV_HIGH, {b[i], 4'h0});
      for (int c = 0; c < 4; c++) begin
        wr(ADDR_CONTROL_ONE, {4'h0, 2'(c), 2'h0});
        cmp(10'(dly), c == 3 ? 10'h000 : b[i] == 0 ? 10'h001
          : 10'((4 >> c) * b[i] + 3));
      end
    end
  endtask
  // Divider split, rate and zero default
  task automatic s_divider();
    logic [9:0] q;
    int n;
    wr(ADDR_DIV_HIGH, 8'hFF);
    rd(ADDR_DIV_HIGH, q);
    cmp(q, 10'h0F3);
    period(n);
    cmp(10'(n), 10'h000);
    wr(ADDR_CONTROL_ONE, 8'h80);
    wr(ADDR_DIV_HIGH, 8'h00);
    wr(ADDR_DIV_LOW, 8'h03);
    period(n);
    cmp(10'(n), 10'h004);
    wr(ADDR_DIV_HIGH, 8'h01);
    wr(ADDR_DIV_LOW, 8'h00);
    period(n);
    cmp(10'(n), 10'h101);
    wr(ADDR_DIV_HIGH, 8'h00);
    period(n);
    cmp(10'(n), DIV_DEFAULT + 10'h001);
    cmp(10'(n >= 79), 10'h001);
    cmp(10'(n_rst), 10'h019);
  endtask
  // General call and wake-up gating
  task automatic s_events();
    wr(ADDR_CONTROL_ONE, 8'hE0);
    @(negedge clk);
    gc = 1'b1;
    sleep = 1'b1;
    match = 1'b1;
    repeat (2) @(negedge clk);
    cmp({8'h00, gcr, wk}, 10'h003);
    wr(ADDR_CONTROL_ONE, 8'h80);
    cmp({8'h00, gcr, wk}, 10'h000);
    @(negedge clk);
    gc = 1'b0;
    sleep = 1'b0;
    match = 1'b0;
  endtask
  // Verdict and end of run
  task automatic conclude();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    s_map();
    s_fields();
    s_delay();
    s_divider();
    s_events();
    conclude();
  end
endmodule
